// >>> sgil_cfg.svh
// offsets, field positions, reset values and timing constants of the gate interlock
`ifndef SGIL_CFG_SVH
`define SGIL_CFG_SVH

`define SGIL_CLK_KHZ 100000
`define SGIL_T_LOCK_MS 600
`define SGIL_T_LOW_MS 500
`define SGIL_PU_RETRIES 3'h7

`define SGIL_REG_CTRL 8'h00
`define SGIL_REG_STATUS 8'h04
`define SGIL_REG_FLAGS 8'h08

`define SGIL_CTRL_RESET 32'h0000_0001
`define SGIL_CTRL_OUT_EN 0

`define SGIL_FLAG_LOCK_FAULT 0
`define SGIL_FLAG_PLAUS_ERR 1
`define SGIL_FLAG_FORCED 2
`define SGIL_FLAGS_W 3

`define SGIL_ST_ACT 0
`define SGIL_ST_CH1 1
`define SGIL_ST_CH2 2
`define SGIL_ST_REQ 3
`define SGIL_ST_HOLD 4
`define SGIL_ST_SAFE_SWITCHING_OUTPUT 5
`define SGIL_ST_LOCK 6
`define SGIL_ST_MAGNET 7
`define SGIL_ST_UNEQUAL 8
`define SGIL_ST_LOCKOUT 9
`define SGIL_ST_PU_DONE 10
`define SGIL_ST_PU_FAIL 11
`define SGIL_ST_TRIES 12

`endif

// >>> sgil_pkg.sv
// types shared by the gate interlock modules
package sgil_pkg;
    typedef logic [7:0] sgil_addr_type;
    typedef logic [31:0] sgil_word_type;

    typedef enum logic [4:0] {
        CH_WAIT_LOW = 5'h01,
        CH_ARMED = 5'h02,
        CH_ON = 5'h04,
        CH_UNEQUAL = 5'h08,
        CH_LOCKOUT = 5'h10
    } sgil_chan_type;

    typedef enum logic [3:0] {
        LK_OPEN = 4'h1,
        LK_WAIT = 4'h2,
        LK_HELD = 4'h4,
        LK_FAIL = 4'h8
    } sgil_lock_type;

    typedef enum logic [2:0] {
        PU_TEST = 3'h1,
        PU_DONE = 3'h2,
        PU_FAIL = 3'h4
    } sgil_pu_type;
endpackage

// >>> sgil_tmr_if.sv
// control and result signals of one interval timer
`timescale 1ns/1ps
`default_nettype none
interface sgil_tmr_if;
    logic start;
    logic run;
    logic expired;
    modport ctl (output start, output run, input expired);
    modport tmr (input start, input run, output expired);
endinterface
`default_nettype wire

// >>> sgil_timer.sv
// interval timer: counts while run is high, flags expiry after limit cycles
`timescale 1ns/1ps
`default_nettype none
module sgil_timer #(
    parameter int unsigned LIMIT = 32'd1
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    sgil_tmr_if.tmr tmr
);
    logic [31:0] cnt;

    // restart on start pulse or when run drops
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cnt <= 32'h0000_0000;
        end else if (tmr.start || !tmr.run) begin
            cnt <= 32'h0000_0000;
        end else if (!tmr.expired) begin
            cnt <= cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            tmr.expired <= 1'b0;
        end else if (tmr.start || !tmr.run) begin
            tmr.expired <= 1'b0;
        end else if (cnt == 32'(LIMIT - 1)) begin
            tmr.expired <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// >>> sgil_interlock.sv
// gate interlock: safety outputs, input plausibility, guard lock and apb registers
//
// Operation
// - outputs high only with actuator and both inputs
// - outputs low without actuator or with inputs low
// - outputs ignore guard lock state
// - lock status rises when actuator arrives
// - lock status stays high if force reached in time
// - lock status stays high while request low
// - lock status drops when actuator leaves
// - lock status drops on holding force timeout
// - after failure, need long low request then high
// - one input drop shows unequal state
// - dropped input returning locks outputs off
// - both inputs low before an accepted rise; after reset the cleared synchronisers already count as both low
// - magnet on only with request and actuator
// - power-up force test with seven retries
// - power-up retries leave lock status alone
// - forced opening shuts the safety outputs
// - input indicator flashes during partial operation
// - lock fault shown on timeout or forced opening
//
// Chosen here: the APB register port and the register addresses.
`include "sgil_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module sgil_interlock #(
    parameter int unsigned HOLD_CYCLES = `SGIL_T_LOCK_MS * `SGIL_CLK_KHZ,
    parameter int unsigned LOW_CYCLES = `SGIL_T_LOW_MS * `SGIL_CLK_KHZ
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic actuator_present_i,
    input wire logic chain_input_ch1_i,
    input wire logic chain_input_ch2_i,
    input wire logic lock_request_in_i,
    input wire logic holding_force_ok_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire sgil_pkg::sgil_addr_type paddr_i,
    input wire sgil_pkg::sgil_word_type pwdata_i,
    output sgil_pkg::sgil_word_type prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic safe_switching_output_ch1_o,
    output logic safe_switching_output_ch2_o,
    output logic lock_status_out_o,
    output logic magnet_on_o,
    output logic input_flash_o,
    output logic lock_fault_o
);
    import sgil_pkg::*;

    logic [5:0] sync1;
    logic [5:0] sync2;
    logic act_s;
    logic ch1_s;
    logic ch2_s;
    logic req_s;
    logic hold_s;
    logic req_d;
    sgil_chan_type ch_state;
    sgil_chan_type next_ch;
    sgil_lock_type lk_state;
    sgil_lock_type next_lk;
    sgil_pu_type pu_state;
    sgil_pu_type next_pu;
    logic [2:0] pu_tries;
    logic pu_retry;
    logic ch_on;
    logic forced;
    logic next_safe_switching_output;
    logic next_status;
    logic [31:0] ctrl;
    logic [`SGIL_FLAGS_W-1:0] flags;
    logic [`SGIL_FLAGS_W-1:0] flag_set;
    logic [`SGIL_FLAGS_W-1:0] flag_clr;
    logic [`SGIL_FLAGS_W-1:0] next_flags;
    logic [31:0] status;
    logic acc;
    logic wr;

    sgil_tmr_if hold_tmr ();
    sgil_tmr_if low_tmr ();

    // two-stage synchronisers for all pin inputs
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            sync1 <= 6'h00;
            sync2 <= 6'h00;
            req_d <= 1'b0;
        end else begin
            sync1 <= {1'b1, holding_force_ok_i, lock_request_in_i, chain_input_ch2_i,
                      chain_input_ch1_i, actuator_present_i};
            sync2 <= sync1;
            req_d <= req_s;
        end
    end

    assign act_s = sync2[0];
    assign ch1_s = sync2[1];
    assign ch2_s = sync2[2];
    assign req_s = sync2[3];
    assign hold_s = sync2[4];

    // input plausibility
    always_comb begin
        next_ch = ch_state;
        case (ch_state)
            CH_WAIT_LOW: begin
                if (!ch1_s && !ch2_s) next_ch = CH_ARMED;
            end
            CH_ARMED: begin
                if (ch1_s && ch2_s) next_ch = CH_ON;
            end
            CH_ON: begin
                if (!ch1_s && !ch2_s) next_ch = CH_ARMED;
                else if (ch1_s != ch2_s) next_ch = CH_UNEQUAL;
            end
            CH_UNEQUAL: begin
                if (!ch1_s && !ch2_s) next_ch = CH_ARMED;
                else if (ch1_s && ch2_s) next_ch = CH_LOCKOUT;
            end
            CH_LOCKOUT: begin
                if (!ch1_s && !ch2_s) next_ch = CH_ARMED;
            end
            default: next_ch = CH_WAIT_LOW;
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ch_state <= CH_WAIT_LOW;
        end else begin
            ch_state <= next_ch;
        end
    end

    assign ch_on = (ch_state == CH_ON);
    // power-up holding force test
    assign pu_retry = (pu_state == PU_TEST) && act_s && req_s && !hold_s &&
                      hold_tmr.expired && (pu_tries != `SGIL_PU_RETRIES);
    always_comb begin
        next_pu = pu_state;
        case (pu_state)
            PU_TEST: begin
                if (sync2[5] && (!act_s || !req_s || hold_s)) begin // inputs settled
                    next_pu = PU_DONE;
                end else if (hold_tmr.expired && pu_tries == `SGIL_PU_RETRIES) begin
                    next_pu = PU_FAIL;
                end
            end
            PU_DONE: next_pu = PU_DONE;
            PU_FAIL: next_pu = PU_FAIL;
            default: next_pu = PU_TEST;
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            pu_state <= PU_TEST;
            pu_tries <= 3'h0;
        end else begin
            pu_state <= next_pu;
            if (pu_retry) begin
                pu_tries <= pu_tries + 3'h1;
            end
        end
    end

    // guard lock sequence
    always_comb begin
        next_lk = lk_state;
        if (!act_s) begin
            next_lk = LK_OPEN;
        end else if (pu_state == PU_TEST) begin
            next_lk = LK_HELD;
        end else begin
            case (lk_state)
                LK_OPEN: next_lk = req_s ? LK_WAIT : LK_HELD;
                LK_HELD: begin
                    if (req_s && !req_d) next_lk = LK_WAIT;
                end
                LK_WAIT: begin
                    if (!req_s) next_lk = LK_HELD;
                    else if (hold_s) next_lk = LK_HELD;
                    else if (hold_tmr.expired) next_lk = LK_FAIL;
                end
                LK_FAIL: begin
                    if (req_s && !req_d && low_tmr.expired) next_lk = LK_WAIT;
                end
                default: next_lk = LK_OPEN;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            lk_state <= LK_OPEN;
        end else begin
            lk_state <= next_lk;
        end
    end

    // timers on the system clock
    assign hold_tmr.run = act_s && req_s && ((pu_state == PU_TEST) || (lk_state == LK_WAIT));
    assign hold_tmr.start = pu_retry || (next_lk == LK_WAIT && lk_state != LK_WAIT);
    assign low_tmr.run = (lk_state == LK_FAIL) && !req_s;
    assign low_tmr.start = 1'b0;

    sgil_timer #(.LIMIT(HOLD_CYCLES)) u_hold_timer (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .tmr(hold_tmr)
    );
    sgil_timer #(.LIMIT(LOW_CYCLES)) u_low_timer (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .tmr(low_tmr)
    );

    // safety outputs, lock status and magnet
    assign forced = (lk_state == LK_HELD) && magnet_on_o && !act_s;
    assign next_safe_switching_output = act_s && ch_on && !forced && (pu_state == PU_DONE) &&
                       ctrl[`SGIL_CTRL_OUT_EN];
    assign next_status = act_s && ((pu_state == PU_TEST) ||
                         (next_lk == LK_WAIT) || (next_lk == LK_HELD));

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            safe_switching_output_ch1_o <= 1'b0;
            safe_switching_output_ch2_o <= 1'b0;
        end else begin
            safe_switching_output_ch1_o <= next_safe_switching_output;
            safe_switching_output_ch2_o <= next_safe_switching_output;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            lock_status_out_o <= 1'b0;
            magnet_on_o <= 1'b0;
            input_flash_o <= 1'b0;
        end else begin
            lock_status_out_o <= next_status;
            magnet_on_o <= act_s && req_s;
            input_flash_o <= (next_ch == CH_UNEQUAL) || (next_ch == CH_LOCKOUT);
        end
    end

    // sticky event flags, set wins over clear
    always_comb begin
        flag_set = '0;
        flag_set[`SGIL_FLAG_LOCK_FAULT] = (next_lk == LK_FAIL && lk_state == LK_WAIT) ||
                                          (next_pu == PU_FAIL && pu_state == PU_TEST);
        flag_set[`SGIL_FLAG_PLAUS_ERR] = (next_ch == CH_LOCKOUT) && (ch_state != CH_LOCKOUT);
        flag_set[`SGIL_FLAG_FORCED] = forced;
        flag_clr = (wr && paddr_i == `SGIL_REG_FLAGS) ? pwdata_i[`SGIL_FLAGS_W-1:0] : '0;
        next_flags = (flags & ~flag_clr) | flag_set;
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            flags <= '0;
            lock_fault_o <= 1'b0;
        end else begin
            flags <= next_flags;
            lock_fault_o <= next_flags[`SGIL_FLAG_LOCK_FAULT] ||
                            next_flags[`SGIL_FLAG_FORCED];
        end
    end

    // apb slave, one wait state per access
    assign acc = psel_i && penable_i && !pready_o;
    assign wr = psel_i && penable_i && pready_o && pwrite_i;

    always_comb begin
        status = 32'h0000_0000;
        status[`SGIL_ST_ACT] = act_s;
        status[`SGIL_ST_CH1] = ch1_s;
        status[`SGIL_ST_CH2] = ch2_s;
        status[`SGIL_ST_REQ] = req_s;
        status[`SGIL_ST_HOLD] = hold_s;
        status[`SGIL_ST_SAFE_SWITCHING_OUTPUT] = safe_switching_output_ch1_o;
        status[`SGIL_ST_LOCK] = lock_status_out_o;
        status[`SGIL_ST_MAGNET] = magnet_on_o;
        status[`SGIL_ST_UNEQUAL] = (ch_state == CH_UNEQUAL);
        status[`SGIL_ST_LOCKOUT] = (ch_state == CH_LOCKOUT);
        status[`SGIL_ST_PU_DONE] = (pu_state == PU_DONE);
        status[`SGIL_ST_PU_FAIL] = (pu_state == PU_FAIL);
        status[`SGIL_ST_TRIES +: 3] = pu_tries;
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end else begin
            pready_o <= acc;
            if (acc) begin
                pslverr_o <= 1'b0;
                prdata_o <= 32'h0000_0000;
                case (paddr_i)
                    `SGIL_REG_CTRL: prdata_o <= pwrite_i ? 32'h0000_0000 : ctrl;
                    `SGIL_REG_STATUS: prdata_o <= pwrite_i ? 32'h0000_0000 : status;
                    `SGIL_REG_FLAGS: prdata_o <= pwrite_i ? 32'h0000_0000 :
                                                 {29'h0000_0000, flags};
                    default: pslverr_o <= 1'b1;
                endcase
            end else begin
                pslverr_o <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl <= `SGIL_CTRL_RESET;
        end else if (wr && paddr_i == `SGIL_REG_CTRL) begin
            ctrl <= {31'h0000_0000, pwdata_i[`SGIL_CTRL_OUT_EN]};
        end
    end

    // checks
    a_safe_switching_output_cause: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        safe_switching_output_ch1_o |-> $past(act_s) && $past(ch_on))
        else $error("safety output high without actuator and both inputs");
    a_safe_switching_output_off_input: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !ch1_s || !ch2_s |-> ##2 !safe_switching_output_ch1_o && !safe_switching_output_ch2_o)
        else $error("safety output high after input loss");
    a_safe_switching_output_off_absent: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !act_s |=> !safe_switching_output_ch1_o && !safe_switching_output_ch2_o)
        else $error("safety output high without actuator");
    a_safe_switching_output_lock_indep: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        act_s && ch_on && (pu_state == PU_DONE) && ctrl[`SGIL_CTRL_OUT_EN] && !forced
        |=> safe_switching_output_ch1_o && safe_switching_output_ch2_o)
        else $error("safety output held off by lock state");
    a_status_enter: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $rose(act_s) |=> lock_status_out_o)
        else $error("lock status not raised on actuator arrival");
    a_status_leave: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !act_s |=> !lock_status_out_o)
        else $error("lock status high without actuator");
    a_hold_timeout: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (lk_state == LK_WAIT) && act_s && req_s && !hold_s && hold_tmr.expired
        && (pu_state != PU_TEST) |=> !lock_status_out_o ##1 !lock_status_out_o)
        else $error("lock status stays high after force timeout");
    a_fail_rearm: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (lk_state == LK_FAIL) && !low_tmr.expired |=> lk_state != LK_WAIT)
        else $error("lock rearmed before minimum low time");
    a_unequal_seen: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        ch_on && (ch1_s != ch2_s) |=> (ch_state == CH_UNEQUAL) && input_flash_o)
        else $error("single channel drop not reported");
    a_lockout_off: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (ch_state == CH_LOCKOUT) |->
        (flags[`SGIL_FLAG_PLAUS_ERR] || $past(ch_state == CH_LOCKOUT)) ##1
        !safe_switching_output_ch1_o && !safe_switching_output_ch2_o)
        else $error("outputs on or no error flag during partial operation lock");
    a_magnet_cause: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        magnet_on_o |-> $past(act_s) && $past(req_s))
        else $error("magnet on without request and actuator");
    a_pu_retries: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (pu_state == PU_FAIL) |-> pu_tries == `SGIL_PU_RETRIES && !safe_switching_output_ch1_o)
        else $error("power-up test gave up early or outputs on");
endmodule
`default_nettype wire

// >>> sgil_partner.sv
// model of the upstream switch chain and the lock request controller
`timescale 1ns/1ps
`default_nettype none
module sgil_partner #(
    parameter int unsigned LOW_CYCLES = 32'd15
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [1:0] ch_cmd_i,
    input wire logic req_cmd_i,
    output logic chain_input_ch1_o,
    output logic chain_input_ch2_o,
    output logic lock_request_in_o
);
    int unsigned low_cnt;

    // chain channels follow the commanded levels, bit 0 is channel 1
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            chain_input_ch1_o <= 1'b0;
            chain_input_ch2_o <= 1'b0;
        end else begin
            chain_input_ch1_o <= ch_cmd_i[0];
            chain_input_ch2_o <= ch_cmd_i[1];
        end
    end

    // request rises only after a low spell two cycles longer than LOW_CYCLES; reset loads the count as already long enough
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            low_cnt <= LOW_CYCLES + 32'h0000_0002;
            lock_request_in_o <= 1'b0;
        end else if (lock_request_in_o) begin
            low_cnt <= 32'h0000_0000;
            lock_request_in_o <= req_cmd_i;
        end else begin
            if (low_cnt < LOW_CYCLES + 32'h0000_0002) begin
                low_cnt <= low_cnt + 32'h0000_0001;
            end
            lock_request_in_o <= req_cmd_i && (low_cnt >= LOW_CYCLES + 32'h0000_0002);
        end
    end
endmodule
`default_nettype wire

// >>> tb.sv
// testbench of the gate interlock with apb register tasks
`include "sgil_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
    import sgil_pkg::*;
    localparam int unsigned HOLD = 20;
    localparam int unsigned LOW = 15;
    localparam int SETTLE = 8;
    logic clk_sys_i, rst_i, prt_rst, act, force_ok, req_cmd, ch1, ch2, req;
    logic [1:0] ch_cmd;
    logic psel, penable, pwrite, pready, pslverr, out1, out2, lock_st, magnet, flash, fault;
    sgil_addr_type paddr;
    sgil_word_type pwdata, prdata, r;
    logic err;
    int mismatches, num_checks, cycles;

    sgil_interlock #(.HOLD_CYCLES(HOLD), .LOW_CYCLES(LOW)) u_sgil_interlock (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .actuator_present_i(act),
        .chain_input_ch1_i(ch1), .chain_input_ch2_i(ch2), .lock_request_in_i(req),
        .holding_force_ok_i(force_ok), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .safe_switching_output_ch1_o(out1),
        .safe_switching_output_ch2_o(out2), .lock_status_out_o(lock_st),
        .magnet_on_o(magnet), .input_flash_o(flash), .lock_fault_o(fault));

    sgil_partner #(.LOW_CYCLES(LOW)) u_sgil_partner (
        .clk_sys_i(clk_sys_i), .rst_i(prt_rst), .ch_cmd_i(ch_cmd), .req_cmd_i(req_cmd),
        .chain_input_ch1_o(ch1), .chain_input_ch2_o(ch2), .lock_request_in_o(req));

    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge clk_sys_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            wrap_up();
        end
    end

    task automatic chk(input string what, input sgil_word_type seen, input sgil_word_type exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask

    task automatic apb(input logic wr, input sgil_addr_type a, input sgil_word_type d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk("pready", sgil_word_type'(pready), 32'h0000_0001);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys_i);
    endtask

    task automatic rdbit(input sgil_addr_type a, input int b, input logic e, input string what);
        apb(1'b0, a, 32'h0000_0000);
        chk(what, sgil_word_type'(r[b]), sgil_word_type'(e));
    endtask

    task automatic pins(input logic o, input logic l);
        chk("safe_out_ch1", sgil_word_type'(out1), sgil_word_type'(o));
        chk("safe_out_ch2", sgil_word_type'(out2), sgil_word_type'(o));
        chk("lock_status", sgil_word_type'(lock_st), sgil_word_type'(l));
    endtask

    task automatic wait_req();
        int n;
        n = 0;
        while (req !== 1'b1 && n < 4 * LOW) begin
            @(posedge clk_sys_i);
            n++;
        end
        chk("lock_request_in", sgil_word_type'(req), 32'h0000_0001);
    endtask

    task automatic tdone(input string name);
        $display("test %s done", name);
    endtask

    initial begin
        rst_i = 1'b1;
        prt_rst = 1'b1;
        {act, force_ok, req_cmd, ch_cmd, psel, penable, pwrite} = '0;
        paddr = '0;
        pwdata = '0;
        {mismatches, num_checks, cycles} = '0;
        cyc(12);
        rst_i <= 1'b0;
        prt_rst <= 1'b0;
        apb(1'b0, `SGIL_REG_CTRL, 32'h0000_0000);
        chk("ctrl reset", r, `SGIL_CTRL_RESET);
        apb(1'b0, `SGIL_REG_FLAGS, 32'h0000_0000);
        chk("flags reset", r, 32'h0000_0000);
        apb(1'b0, 8'h0C, 32'h0000_0000);
        chk("unmapped error", sgil_word_type'(err), 32'h0000_0001);
        chk("unmapped data", r, 32'h0000_0000);
        tdone("registers");
        act <= 1'b1;
        cyc(SETTLE);
        pins(1'b0, 1'b1);
        rdbit(`SGIL_REG_STATUS, `SGIL_ST_PU_DONE, 1'b1, "pu done");
        ch_cmd <= 2'b11;
        cyc(SETTLE);
        pins(1'b1, 1'b1);
        chk("magnet idle", sgil_word_type'(magnet), 32'h0000_0000);
        apb(1'b1, `SGIL_REG_CTRL, 32'h0000_0000);
        cyc(SETTLE);
        pins(1'b0, 1'b1);
        apb(1'b1, `SGIL_REG_CTRL, 32'h0000_0001);
        cyc(SETTLE);
        pins(1'b1, 1'b1);
        act <= 1'b0;
        cyc(SETTLE);
        pins(1'b0, 1'b0);
        act <= 1'b1;
        cyc(SETTLE);
        pins(1'b1, 1'b1);
        tdone("outputs");
        force_ok <= 1'b1;
        req_cmd <= 1'b1;
        wait_req();
        cyc(SETTLE);
        chk("magnet on", sgil_word_type'(magnet), 32'h0000_0001);
        cyc(HOLD + SETTLE);
        pins(1'b1, 1'b1);
        act <= 1'b0;
        cyc(SETTLE);
        pins(1'b0, 1'b0);
        chk("magnet off", sgil_word_type'(magnet), 32'h0000_0000);
        chk("fault forced", sgil_word_type'(fault), 32'h0000_0001);
        rdbit(`SGIL_REG_FLAGS, `SGIL_FLAG_FORCED, 1'b1, "forced flag");
        apb(1'b1, `SGIL_REG_FLAGS, 32'h0000_0007);
        apb(1'b0, `SGIL_REG_FLAGS, 32'h0000_0000);
        chk("flags cleared", r, 32'h0000_0000);
        chk("fault cleared", sgil_word_type'(fault), 32'h0000_0000);
        tdone("guard lock");
        act <= 1'b1;
        force_ok <= 1'b0;
        req_cmd <= 1'b0;
        cyc(SETTLE);
        pins(1'b1, 1'b1);
        req_cmd <= 1'b1;
        wait_req();
        cyc(SETTLE);
        pins(1'b1, 1'b1);
        cyc(HOLD + 2);
        pins(1'b1, 1'b0);
        chk("fault timeout", sgil_word_type'(fault), 32'h0000_0001);
        rdbit(`SGIL_REG_FLAGS, `SGIL_FLAG_LOCK_FAULT, 1'b1, "lock fault flag");
        force_ok <= 1'b1;
        cyc(SETTLE);
        pins(1'b1, 1'b0);
        req_cmd <= 1'b0;
        cyc(2);
        req_cmd <= 1'b1;
        wait_req();
        cyc(SETTLE);
        pins(1'b1, 1'b1);
        apb(1'b1, `SGIL_REG_FLAGS, 32'h0000_0001);
        tdone("holding force");
        ch_cmd <= 2'b10;
        cyc(SETTLE);
        pins(1'b0, 1'b1);
        chk("flash unequal", sgil_word_type'(flash), 32'h0000_0001);
        rdbit(`SGIL_REG_STATUS, `SGIL_ST_UNEQUAL, 1'b1, "unequal");
        ch_cmd <= 2'b11;
        cyc(SETTLE);
        pins(1'b0, 1'b1);
        chk("flash lockout", sgil_word_type'(flash), 32'h0000_0001);
        rdbit(`SGIL_REG_STATUS, `SGIL_ST_LOCKOUT, 1'b1, "partial lock");
        rdbit(`SGIL_REG_FLAGS, `SGIL_FLAG_PLAUS_ERR, 1'b1, "plausibility flag");
        ch_cmd <= 2'b00;
        cyc(SETTLE);
        ch_cmd <= 2'b11;
        cyc(SETTLE);
        pins(1'b1, 1'b1);
        chk("flash off", sgil_word_type'(flash), 32'h0000_0000);
        tdone("plausibility");
        // device reset only: actuator and lock request stay present across it
        rst_i <= 1'b1;
        force_ok <= 1'b0;
        ch_cmd <= 2'b00;
        cyc(4);
        rst_i <= 1'b0;
        cyc(1);
        act <= 1'b1;
        cyc(SETTLE);
        ch_cmd <= 2'b11;
        cyc(SETTLE);
        pins(1'b0, 1'b1);
        cyc(8 * HOLD + 40);
        rdbit(`SGIL_REG_STATUS, `SGIL_ST_PU_FAIL, 1'b1, "pu fail");
        chk("pu retries", sgil_word_type'(r[14:12]), sgil_word_type'(`SGIL_PU_RETRIES));
        chk("safe_out after fail", sgil_word_type'(out1), 32'h0000_0000);
        tdone("power-up");
        wrap_up();
    end
endmodule
`default_nettype wire
